/* File: psw_status_word.sv */
`default_nettype none
module psw_status_word
   import psw_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // ALU side
   input wire logic [1:0] op_i,
   input wire logic carry7_i,
   input wire logic carry3_i,
   input wire logic ovf_i,
   input wire logic [15:0] product_i,
   input wire logic [7:0] acc_i,
   // Status outputs
   output logic [7:0] psw_o,
   output logic [4:0] bank_base_o,
   output logic [1:0] bank_sel_o
);
   logic cy_ff, ac_ff, f0_ff, f1_ff, ov_ff;
   logic [1:0] rs_ff;
   logic [7:0] rdata_ff;
   logic nxt_cy, nxt_ac, nxt_ov;
   logic sfr_wr;
   logic mul_big;
   psw_op_t op;
   psw_alu_if pif ();
   psw_alu_if bif ();

   assign op = psw_op_t'(op_i);
   assign sfr_wr = wr_i && (addr_i == PSW_ADDR);
   assign mul_big = (product_i[15:8] != 8'h00);

   assign pif.acc = acc_i;
   assign bif.bank = rs_ff;
   psw_parity u_par (.pif(pif.src));
   psw_bank u_bank (.bif(bif.bsrc));

   // ALU update wins over a software write in the same cycle, as the flag is hardware set
   always_comb begin
      nxt_cy = cy_ff;
      nxt_ac = ac_ff;
      nxt_ov = ov_ff;
      if (sfr_wr) begin
         nxt_cy = wdata_i[POS_CY];
         nxt_ac = wdata_i[POS_AC];
         nxt_ov = wdata_i[POS_OV];
      end
      unique case (op)
         PSW_OP_ARITH: begin
            nxt_cy = carry7_i;
            nxt_ac = carry3_i;
            nxt_ov = ovf_i;
         end
         PSW_OP_MUL: begin
            nxt_cy = 1'b0;
            nxt_ov = mul_big;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cy_ff <= PSW_RESET[POS_CY];
         ac_ff <= PSW_RESET[POS_AC];
         ov_ff <= PSW_RESET[POS_OV];
      end else if (ce_i) begin
         cy_ff <= nxt_cy;
         ac_ff <= nxt_ac;
         ov_ff <= nxt_ov;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         f0_ff <= PSW_RESET[POS_F0];
         f1_ff <= PSW_RESET[POS_F1];
         rs_ff <= PSW_RESET[POS_RS1:POS_RS0];
      end else if (ce_i && sfr_wr) begin
         f0_ff <= wdata_i[POS_F0];
         f1_ff <= wdata_i[POS_F1];
         rs_ff <= wdata_i[POS_RS1:POS_RS0];
      end
   end

   always_comb begin
      psw_o = 8'h00;
      psw_o[POS_CY] = cy_ff;
      psw_o[POS_AC] = ac_ff;
      psw_o[POS_F0] = f0_ff;
      psw_o[POS_RS1:POS_RS0] = rs_ff;
      psw_o[POS_OV] = ov_ff;
      psw_o[POS_F1] = f1_ff;
      psw_o[POS_P] = pif.parity;
   end

   // Unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rdata_ff <= 8'h00;
      end else if (ce_i) begin
         rdata_ff <= (rd_i && addr_i == PSW_ADDR) ? psw_o : 8'h00;
      end
   end
   assign rdata_o = rdata_ff;
   assign bank_base_o = bif.bank_base;
   assign bank_sel_o = rs_ff;

   property p_carry;
      @(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && op == PSW_OP_ARITH) |=> (cy_ff == $past(carry7_i));
   endproperty
   a_carry: assert property (p_carry) else $error("carry flag wrong");

   property p_aux;
      @(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && op == PSW_OP_ARITH) |=> (ac_ff == $past(carry3_i));
   endproperty
   a_aux: assert property (p_aux) else $error("aux carry wrong");

   property p_mul;
      @(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && op == PSW_OP_MUL) |=> (ov_ff == ($past(product_i) > 16'h00FF));
   endproperty
   a_mul: assert property (p_mul) else $error("multiply overflow wrong");

   property p_bank;
      @(posedge clk_i) disable iff (sys_rst_i)
      1'b1 |-> (bank_base_o == {rs_ff, 3'b000});
   endproperty
   a_bank: assert property (p_bank) else $error("bank base wrong");

   property p_parity;
      @(posedge clk_i) disable iff (sys_rst_i)
      1'b1 |-> (psw_o[POS_P] == ^acc_i);
   endproperty
   a_parity: assert property (p_parity) else $error("parity wrong");

   property p_user;
      @(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && sfr_wr) |=> (f0_ff == $past(wdata_i[POS_F0]) && f1_ff == $past(wdata_i[POS_F1]));
   endproperty
   a_user: assert property (p_user) else $error("user flag write lost");

   property p_rsel;
      @(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && sfr_wr) |=> (bank_sel_o == $past(wdata_i[4:3]));
   endproperty
   a_rsel: assert property (p_rsel) else $error("bank select write lost");

   property p_hold;
      @(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && op == PSW_OP_NONE && !sfr_wr) |=> $stable(cy_ff) && $stable(ac_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("carry changed without cause");

   property p_read;
      @(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && rd_i && addr_i == PSW_ADDR) |=> (rdata_o[7:1] == $past(psw_o[7:1]));
   endproperty
   a_read: assert property (p_read) else $error("read data wrong");

   c_mul_big: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && op == PSW_OP_MUL && mul_big);
   c_arith_carry: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && op == PSW_OP_ARITH && carry7_i && carry3_i);
   c_bank3: cover property (@(posedge clk_i) disable iff (sys_rst_i) rs_ff == 2'b11);
   c_read: cover property (@(posedge clk_i) disable iff (sys_rst_i) rd_i && addr_i == PSW_ADDR);
endmodule
`default_nettype wire

/* File: psw_pkg.sv */
`default_nettype none
package psw_pkg;
   localparam logic [7:0] PSW_ADDR = 8'hD0;
   localparam logic [7:0] PSW_RESET = 8'h00;
   localparam int POS_CY = 7;
   localparam int POS_AC = 6;
   localparam int POS_F0 = 5;
   localparam int POS_RS1 = 4;
   localparam int POS_RS0 = 3;
   localparam int POS_OV = 2;
   localparam int POS_F1 = 1;
   localparam int POS_P = 0;
   localparam logic [8:0] MUL_LIMIT = 9'h0FF;
   localparam logic [4:0] BANK_SPAN = 5'h08;
   typedef enum logic [1:0] {
      PSW_OP_NONE = 2'b00,
      PSW_OP_ARITH = 2'b01,
      PSW_OP_MUL = 2'b11
   } psw_op_t;
endpackage
`default_nettype wire

/* File: psw_alu_if.sv */
`default_nettype none
interface psw_alu_if;
   import psw_pkg::*;
   logic [7:0] acc;
   logic parity;
   logic [1:0] bank;
   logic [4:0] bank_base;
   modport src (input acc, output parity);
   modport dst (output acc, input parity);
   modport bsrc (input bank, output bank_base);
   modport bdst (output bank, input bank_base);
endinterface
`default_nettype wire

/* File: psw_parity.sv */
`default_nettype none
module psw_parity
   import psw_pkg::*;
(
   // Accumulator in, parity out
   psw_alu_if.src pif
);
   logic [8:0] chain;
   assign chain[0] = 1'b0;
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_bit
         assign chain[g+1] = chain[g] ^ pif.acc[g];
      end
   endgenerate
   assign pif.parity = chain[8];
endmodule
`default_nettype wire

/* File: psw_bank.sv */
`default_nettype none
module psw_bank
   import psw_pkg::*;
(
   // Bank select in, RAM base out
   psw_alu_if.bsrc bif
);
   always_comb begin
      unique case (bif.bank)
         2'b00: bif.bank_base = 5'h00;
         2'b01: bif.bank_base = BANK_SPAN;
         2'b10: bif.bank_base = 5'h10;
         2'b11: bif.bank_base = 5'h18;
      endcase
   end
endmodule
`default_nettype wire

/* File: psw_alu_model.sv */
`default_nettype none
module psw_alu_model (
   // Request from bench
   input wire logic [1:0] req_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   // ALU side
   output logic [1:0] op_o,
   output logic carry7_o,
   output logic carry3_o,
   output logic ovf_o,
   output logic [15:0] product_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] sum;
   logic [4:0] low;
   assign sum = {1'b0, a_i} + {1'b0, b_i};
   assign low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
   assign op_o = req_i;
   assign carry7_o = sum[8];
   assign carry3_o = low[4];
   assign ovf_o = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
   assign product_o = {8'h00, a_i} * {8'h00, b_i};
endmodule
`default_nettype wire

/* File: status_word_flags_tb_top.sv */
`default_nettype none
module status_word_flags_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import psw_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic ce = 1'b1;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic [7:0] acc_i = 8'h00;
   logic [7:0] a = 8'h00;
   logic [7:0] b = 8'h00;
   logic [1:0] req = 2'b00;
   logic [1:0] op;
   logic c7, c3, ov;
   logic [15:0] prod;
   logic [7:0] rdata_o, psw_o;
   logic [4:0] bank_base_o;
   logic [1:0] bank_sel_o;
   int n_mismatch = 0;
   int comparisons = 0;
   always #10 clk_i = ~clk_i;
   psw_alu_model psw_alu_model_inst (.req_i(req), .a_i(a), .b_i(b), .op_o(op),
      .carry7_o(c7), .carry3_o(c3), .ovf_o(ov), .product_o(prod));
   psw_status_word psw_status_word_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .op_i(op), .carry7_i(c7), .carry3_i(c3), .ovf_i(ov), .product_i(prod),
      .acc_i(acc_i), .psw_o(psw_o), .bank_base_o(bank_base_o), .bank_sel_o(bank_sel_o));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // One strobe cycle; the registered answer is sampled 1 ns after the edge that ends it
   task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= w;
      rd_i <= ~w;
      addr_i <= ad;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      #1;
   endtask
   task automatic alu(input logic [1:0] r, input logic [7:0] x, input logic [7:0] y);
      @(posedge clk_i);
      req <= r;
      a <= x;
      b <= y;
      @(posedge clk_i);
      req <= 2'b00;
      #1;
   endtask
   // Arith gives {carry7, carry3}; multiply gives {0, product above 0FFH}
   function automatic logic [1:0] exp_f(logic [1:0] r, logic [7:0] x, logic [7:0] y);
      logic [8:0] s;
      logic [4:0] l;
      logic [15:0] p;
      s = {1'b0, x} + {1'b0, y};
      l = {1'b0, x[3:0]} + {1'b0, y[3:0]};
      p = {8'h00, x} * {8'h00, y};
      if (r == 2'b11) begin
         return {1'b0, p > 16'h00FF};
      end
      return {s[8], l[4]};
   endfunction
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      logic [7:0] w, x, y;
      logic [1:0] r;
      logic [7:0] cx [4] = '{8'hFF, 8'h10, 8'h0F, 8'hFF};
      logic [7:0] cy [4] = '{8'h01, 8'h10, 8'h01, 8'h01};
      void'($urandom(11493));
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1;
      chk(psw_o, PSW_RESET, "reset");
      // Bit 0 written high must not stick, parity follows the accumulator
      for (int i = 0; i < 4; i++) begin
         w = (8'($urandom) & 8'h22) | 8'(i << 3);
         bus(1'b1, PSW_ADDR, w | 8'h01);
         chk({3'h0, bank_base_o}, 8'(i * 8), "bank base");
         chk({6'h00, bank_sel_o}, 8'(i), "bank sel");
         bus(1'b0, PSW_ADDR, 8'h00);
         chk(rdata_o, w, "readback");
      end
      bus(1'b1, 8'hD1, 8'h00);
      chk(psw_o, w, "unmapped write");
      bus(1'b0, 8'hD1, 8'h00);
      chk(rdata_o, 8'h00, "unmapped read");
      // Enable low must freeze the word, so a write then is lost
      @(posedge clk_i);
      ce <= 1'b0;
      bus(1'b1, PSW_ADDR, 8'hFE);
      chk(psw_o, w, "frozen write");
      @(posedge clk_i);
      ce <= 1'b1;
      $display("test registers done");
      for (int i = 0; i < 60; i++) begin
         r = i[0] ? 2'b11 : 2'b01;
         x = (i < 4) ? cx[i] : 8'($urandom);
         y = (i < 4) ? cy[i] : 8'($urandom);
         acc_i <= 8'($urandom);
         alu(r, x, y);
         chk({7'h00, psw_o[POS_P]}, {7'h00, ^acc_i}, "parity");
         if (r == 2'b01) begin
            chk({6'h00, psw_o[POS_CY], psw_o[POS_AC]}, {6'h00, exp_f(r, x, y)}, "arith");
         end else begin
            chk({6'h00, psw_o[POS_CY], psw_o[POS_OV]}, {6'h00, exp_f(r, x, y)}, "mul");
         end
      end
      $display("test alu done");
      report_and_stop();
   end
endmodule
`default_nettype wire
